/* cyc_pkg.sv */
// Constants for the cycle counter and fault address block
package cyc_pkg;
  localparam int unsigned enable_bit = 32;
  localparam int unsigned load_hi = 31;
  localparam int unsigned load_lo = 4;
  localparam logic [31:0] low_reset = 32'h0000_0000;
  localparam logic [31:0] high_reset = 32'h0000_0000;
  localparam logic [63:0] addr_reset = 64'h0000_0000_0000_0000;
  localparam logic [31:0] load_mask = 32'hFFFF_FFF0;
  // Register select codes on the privileged move port
  typedef enum logic [1:0] {
    sel_none,
    sel_cycle_count,
    sel_count_control,
    sel_fault_addr
  } reg_sel_t;
endpackage

/* low_counter.sv */
// Lower half of the cycle count: enable, load and wrap
`timescale 1ns/10ps
module low_counter #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Control write
  input wire logic ctl_wr,
  input wire logic [63:0] ctl_data,
  // State
  output logic [WIDTH-1:0] count_q,
  output logic enable_q
);
  logic [WIDTH-1:0] count_d;

  always_comb begin
    if (ctl_wr) begin
      // Low nibble cleared, reserved bits masked off
      count_d = ctl_data[WIDTH-1:0] & cyc_pkg::load_mask;
    end else if (enable_q) begin
      // Plain modulo add, no carry out to the upper half
      count_d = count_q + WIDTH'(1);
    end else begin
      count_d = count_q;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= cyc_pkg::low_reset;
    end else begin
      count_q <= count_d;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      enable_q <= 1'b0;
    end else if (ctl_wr) begin
      enable_q <= ctl_data[cyc_pkg::enable_bit];
    end
  end

  chk_wrap_zero: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (enable_q && !ctl_wr && count_q == '1) |=> count_q == '0)
    else $error("lower count did not wrap");
  chk_nibble_clear: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    ctl_wr |=> count_q[3:0] == 4'h0)
    else $error("low nibble not cleared on control write");
endmodule

/* cycle_counter_and_fault_va.sv */
// Cycle counter and fault virtual address processor registers
`timescale 1ns/10ps
module cycle_counter_and_fault_va (
  // Clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Privileged register move port
  input wire logic mtpr_valid,
  input wire logic [1:0] mtpr_sel,
  input wire logic [63:0] mtpr_data,
  // Privileged read port
  input wire logic mfpr_valid,
  input wire logic [1:0] mfpr_sel,
  // Read-cycle-count instruction
  input wire logic rdcyc_valid,
  // Data translation fault report
  input wire logic dfault_valid,
  input wire logic dfault_pte_load,
  input wire logic [63:0] dfault_addr,
  // Results
  output logic rdata_valid_q,
  output logic [63:0] rdata_q,
  output logic [63:0] fault_addr_q,
  output logic count_enable_q
);
  ////////////////////////////////////////////////////////////////////////
  // Select decode, shared by the write and read paths
  function automatic logic sel_hit(
    input logic strobe,
    input logic [1:0] sel,
    input cyc_pkg::reg_sel_t target
  );
    return strobe && (sel == 2'(target));
  endfunction

  // Full view of the cycle count as software reads it
  function automatic logic [63:0] full_count(
    input logic [31:0] upper,
    input logic [31:0] lower
  );
    return {upper, lower};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [31:0] high_q;
  logic [31:0] low_count;
  logic low_enable;
  logic ctl_wr;
  logic upper_wr;
  logic any_rd;
  logic rd_count;
  logic rd_addr;

  assign ctl_wr = sel_hit(mtpr_valid, mtpr_sel,
    cyc_pkg::sel_count_control);
  assign upper_wr = sel_hit(mtpr_valid, mtpr_sel,
    cyc_pkg::sel_cycle_count);
  assign any_rd = rdcyc_valid || mfpr_valid;
  // Read-cycle-count wins over a privileged read in the same cycle
  assign rd_count = rdcyc_valid ||
    sel_hit(mfpr_valid, mfpr_sel, cyc_pkg::sel_cycle_count);
  assign rd_addr = !rdcyc_valid &&
    sel_hit(mfpr_valid, mfpr_sel, cyc_pkg::sel_fault_addr);

  low_counter #(.WIDTH(32)) u_low (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ctl_wr(ctl_wr),
    .ctl_data(mtpr_data),
    .count_q(low_count),
    .enable_q(low_enable)
  );

  ////////////////////////////////////////////////////////////////////////
  // Upper half is storage only; the lower half never carries into it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      high_q <= cyc_pkg::high_reset;
    end else if (upper_wr) begin
      high_q <= mtpr_data[63:32];
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_enable_q <= 1'b0;
    end else if (ctl_wr) begin
      count_enable_q <= mtpr_data[cyc_pkg::enable_bit];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault address capture; page table entry loads leave it alone
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_addr_q <= cyc_pkg::addr_reset;
    end else if (dfault_valid && !dfault_pte_load) begin
      fault_addr_q <= dfault_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read answer strobe: one cycle after any read request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_valid_q <= 1'b0;
    end else begin
      rdata_valid_q <= any_rd;
    end
  end

  // Read data holds between reads so a slow consumer still sees it;
  // the write-only control register and the unused code read as zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 64'h0000_0000_0000_0000;
    end else if (rd_count) begin
      rdata_q <= full_count(high_q, low_count);
    end else if (rd_addr) begin
      rdata_q <= fault_addr_q;
    end else if (any_rd) begin
      rdata_q <= 64'h0000_0000_0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Counter behaviour
  chk_count_advance: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (low_enable && !ctl_wr) |=>
      low_count == $past(low_count) + 32'h0000_0001)
    else $error("count did not advance");

  chk_count_hold: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (!low_enable && !ctl_wr) |=> $stable(low_count))
    else $error("count moved while disabled");

  chk_ena_mirror: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    count_enable_q == low_enable)
    else $error("enable copies disagree");

  chk_ctl_load: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    ctl_wr |=>
      low_count == ($past(mtpr_data[31:0]) & cyc_pkg::load_mask)
      && count_enable_q == $past(mtpr_data[cyc_pkg::enable_bit]))
    else $error("control write load wrong");

  ////////////////////////////////////////////////////////////////////////
  // Upper half storage
  chk_high_only: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (upper_wr && !low_enable && !ctl_wr) |=>
      high_q == $past(mtpr_data[63:32]) && $stable(low_count))
    else $error("cycle count write disturbed lower half");

  chk_high_hold: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    !upper_wr |=> $stable(high_q))
    else $error("upper half changed without write");

  chk_wrap_upper: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (low_enable && low_count == 32'hFFFF_FFFF && !upper_wr) |=>
      $stable(high_q))
    else $error("lower wrap carried into upper half");

  ////////////////////////////////////////////////////////////////////////
  // Read path
  chk_rdcyc_value: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    rdcyc_valid |=> rdata_valid_q
      && rdata_q == full_count($past(high_q), $past(low_count)))
    else $error("read cycle count value wrong");

  chk_mfpr_count: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (mfpr_valid && rd_count) |=>
      rdata_q == full_count($past(high_q), $past(low_count)))
    else $error("privileged count read value wrong");

  chk_rdata_pulse: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    !any_rd |=> !rdata_valid_q)
    else $error("read answer stood too long");

  chk_rdata_hold: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    !any_rd |=> $stable(rdata_q))
    else $error("read data changed without a read");

  chk_ctl_zero_read: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (any_rd && !rd_count && !rd_addr) |=> rdata_q == '0)
    else $error("write-only register read not zero");

  ////////////////////////////////////////////////////////////////////////
  // Fault address capture
  chk_addr_capture: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (dfault_valid && !dfault_pte_load) |=>
      fault_addr_q == $past(dfault_addr))
    else $error("fault address not captured");

  chk_addr_pte_skip: assert property (@(posedge core_clk)
    disable iff (!arst_n)
    (dfault_valid && dfault_pte_load) |=> $stable(fault_addr_q))
    else $error("fault address written by pte load");

  ////////////////////////////////////////////////////////////////////////
  // Main scenarios
  cov_wrap: cover property (@(posedge core_clk) disable iff (!arst_n)
    low_enable && low_count == 32'hFFFF_FFFF ##1 low_count == '0);

  cov_ctl_write: cover property (@(posedge core_clk) disable iff (!arst_n)
    ctl_wr ##1 low_enable ##3 rdcyc_valid);

  cov_pte_fault: cover property (@(posedge core_clk) disable iff (!arst_n)
    dfault_valid && dfault_pte_load);

  cov_upper_write: cover property (@(posedge core_clk)
    disable iff (!arst_n)
    upper_wr ##[1:8] rdcyc_valid);

  cov_addr_read: cover property (@(posedge core_clk)
    disable iff (!arst_n)
    (dfault_valid && !dfault_pte_load) ##[1:8] rd_addr);
endmodule

/* cycle_counter_and_fault_va_tb.sv */
// Self-checking bench for the cycle counter and fault address block
`timescale 1ns/10ps
module cycle_counter_and_fault_va_tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic mtpr_valid = 1'b0;
  logic [1:0] mtpr_sel = 2'h0;
  logic [63:0] mtpr_data = 64'h0000_0000_0000_0000;
  logic mfpr_valid = 1'b0;
  logic [1:0] mfpr_sel = 2'h0;
  logic rdcyc_valid = 1'b0;
  logic dfault_valid = 1'b0;
  logic dfault_pte_load = 1'b0;
  logic [63:0] dfault_addr = 64'h0000_0000_0000_0000;
  logic rdata_valid_q;
  logic [63:0] rdata_q;
  logic [63:0] fault_addr_q;
  logic count_enable_q;
  int n_errors = 0;
  int check_count = 0;
  always #5 core_clk = ~core_clk;
  cycle_counter_and_fault_va dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .mtpr_valid(mtpr_valid),
    .mtpr_sel(mtpr_sel), .mtpr_data(mtpr_data), .mfpr_valid(mfpr_valid),
    .mfpr_sel(mfpr_sel), .rdcyc_valid(rdcyc_valid),
    .dfault_valid(dfault_valid), .dfault_pte_load(dfault_pte_load),
    .dfault_addr(dfault_addr), .rdata_valid_q(rdata_valid_q),
    .rdata_q(rdata_q), .fault_addr_q(fault_addr_q),
    .count_enable_q(count_enable_q));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string name, input logic [63:0] exp, got);
    check_count++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [63:0] data);
    @(posedge core_clk);
    mtpr_valid <= 1'b1;
    mtpr_sel <= sel;
    mtpr_data <= data;
    @(posedge core_clk);
    mtpr_valid <= 1'b0;
    #1;
  endtask
  // Read strobe; t is the edge that takes it, so spacing is exact
  task automatic rd(input logic cc, input logic [1:0] sel,
                    output logic [63:0] d, output time t);
    int i;
    @(posedge core_clk);
    rdcyc_valid <= cc;
    mfpr_valid <= !cc;
    mfpr_sel <= sel;
    @(posedge core_clk);
    t = $time;
    rdcyc_valid <= 1'b0;
    mfpr_valid <= 1'b0;
    #1;
    for (i = 0; i < 4 && rdata_valid_q !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (rdata_valid_q !== 1'b1) begin
      $display("[FAIL] read answer expected 1 seen %b", rdata_valid_q);
      n_errors++;
    end
    d = rdata_q;
    // Answer strobe is a one-cycle pulse, data holds after it
    @(posedge core_clk);
    #1;
    chk("answer pulse", 64'h0, {63'h0, rdata_valid_q});
    chk("answer held", d, rdata_q);
  endtask
  task automatic flt(input logic pte, input logic [63:0] va);
    @(posedge core_clk);
    dfault_valid <= 1'b1;
    dfault_pte_load <= pte;
    dfault_addr <= va;
    @(posedge core_clk);
    dfault_valid <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Disabled load keeps the value exact, so loaded bits can be compared
  task automatic t_load();
    logic [63:0] d;
    time t;
    rd(1'b0, 2'h1, d, t);
    chk("reset count", 64'h0000_0000_0000_0000, d);
    wr(2'h2, 64'hFFFF_FFFE_ABCD_123F);
    chk("enable off", 64'h0, {63'h0, count_enable_q});
    repeat (5) @(posedge core_clk);
    rd(1'b1, 2'h0, d, t);
    chk("loaded count", 64'h0000_0000_ABCD_1230, d);
    wr(2'h1, 64'h5A5A_A5A5_5A5A_A5A5);
    rd(1'b1, 2'h0, d, t);
    chk("upper write", 64'h5A5A_A5A5_ABCD_1230, d);
    rd(1'b0, 2'h2, d, t);
    chk("control read", 64'h0000_0000_0000_0000, d);
  endtask
  // Two reads a known gap apart across the wrap point
  task automatic t_run();
    logic [63:0] d1, d2;
    time t1, t2;
    wr(2'h2, 64'h0000_0001_FFFF_FFF5);
    chk("enable on", 64'h1, {63'h0, count_enable_q});
    rd(1'b1, 2'h0, d1, t1);
    repeat (40) @(posedge core_clk);
    rd(1'b1, 2'h0, d2, t2);
    chk("count step", {32'h0, d1[31:0] + 32'((t2 - t1) / 10)},
        {32'h0, d2[31:0]});
    chk("wrapped", 64'h1, {63'h0, d2[31:0] < d1[31:0]});
    chk("upper kept", 64'h5A5A_A5A5_5A5A_A5A5,
        {d2[63:32], d2[63:32]});
  endtask
  task automatic t_fault();
    logic [63:0] d;
    time t;
    flt(1'b0, 64'h1234_5678_9ABC_DEF0);
    chk("fault addr", 64'h1234_5678_9ABC_DEF0, fault_addr_q);
    flt(1'b1, 64'h0FED_CBA9_8765_4321);
    chk("pte load", 64'h1234_5678_9ABC_DEF0, fault_addr_q);
    wr(2'h3, 64'h5555_5555_5555_5555);
    rd(1'b0, 2'h3, d, t);
    chk("addr read only", 64'h1234_5678_9ABC_DEF0, d);
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    arst_n <= 1'b1;
    t_load();
    t_run();
    t_fault();
    wrap_up();
  end
endmodule
